/* File: logic/ctfs_pkg.sv */
// Purpose: constants and types for the current and temperature fault supervisor
// Assumes: limits and measurements share one linear scale
// Notes:   register offsets are command codes of the management bus
package ctfs_pkg;
  localparam logic [7:0]  OFS_OC_FAULT_THRESH = 8'h46;
  localparam logic [7:0]  OFS_OC_FAULT_ACTION = 8'h47;
  localparam logic [7:0]  OFS_OC_WARN_THRESH  = 8'h4A;
  localparam logic [7:0]  OFS_OT_FAULT_THRESH = 8'h4F;
  localparam logic [7:0]  OFS_OT_FAULT_ACTION = 8'h50;
  localparam logic [7:0]  OFS_OT_WARN_THRESH  = 8'h51;
  localparam logic [7:0]  OC_FAULT_ACTION_VAL = 8'hFA;
  localparam logic [7:0]  OT_FAULT_ACTION_VAL = 8'hF8;
  localparam logic [15:0] OT_FAULT_RST        = 16'h007D;
  localparam logic [15:0] OT_WARN_RST         = 16'h005F;
  localparam int          EXP_MSB             = 15;
  localparam int          EXP_LSB             = 11;
  localparam int          MAN_MSB             = 10;
  localparam logic [15:0] OT_HYST_DEG         = 16'h000F;
  localparam int          OC_FAULT_PCT        = 125;
  localparam int          RETRY_MS            = 22;
  localparam int          CLK_KHZ             = 25000;
  localparam int          RETRY_CYC           = RETRY_MS * CLK_KHZ;
  // status bit positions
  localparam int SB_IOUT_OC  = 4;
  localparam int SB_TEMP     = 2;
  localparam int SB_OTHER    = 0;
  localparam int SW_IOUT     = 14;
  localparam int SI_OC_FAULT = 7;
  localparam int SI_OC_WARN  = 5;
  localparam int ST_OT_FAULT = 7;
  localparam int ST_OT_WARN  = 6;

  typedef struct packed {
    logic [15:0] oc_fault;
    logic [15:0] oc_warn;
    logic [15:0] ot_fault;
    logic [15:0] ot_warn;
  } ctfs_limits_t;

  typedef struct packed {
    logic [7:0]  status_byte;
    logic [15:0] status_word;
    logic [7:0]  status_iout;
    logic [7:0]  status_temp;
  } ctfs_status_t;
endpackage : ctfs_pkg

/* File: logic/ctfs_supervisor.sv */
// Purpose: current and temperature fault supervisor of a multi-phase regulator
// Assumes: bus framing decoded upstream into command code, strobes and data
// Notes:   measurements arrive in plain units (A, degC) on the same clock
`timescale 1ns/1ps
module ctfs_supervisor
  import ctfs_pkg::*;
#(
  parameter logic [15:0] RATED_MAX_CURRENT = 16'h0064, // rated current in A
  parameter int          RETRY_CYCLES      = RETRY_CYC // shorten in simulation
) (
  input  wire logic        clk_in,              // 25 MHz clock
  input  wire logic        rst_in,              // sync reset, high
  input  wire logic [7:0]  cmd_in,              // command code
  input  wire logic        wr_in,               // write strobe
  input  wire logic        rd_in,               // read strobe
  input  wire logic [15:0] wdata_in,            // write data
  input  wire logic        clear_faults_in,     // clear status pulse
  input  wire logic [15:0] iout_meas_in,        // output current, A, signed
  input  wire logic [15:0] temp_meas_in,        // temperature, degC, signed
  output logic      [15:0] rdata_out,           // read data
  output logic             rvalid_out,          // read data valid
  output logic             host_alert_out,      // alert to host, high
  output logic             regulator_fault_pin, // fault pin, high
  output logic             output_enable_out,   // power stage enable
  output ctfs_status_t     status_out           // status registers
);
  typedef enum {RUN, OC_WAIT, OT_COOL} ctfs_mode_t;

  typedef struct packed {
    ctfs_limits_t lim;
    ctfs_status_t st;
    ctfs_mode_t   mode;
    logic [31:0]  cnt;
    logic [15:0]  rdata;
    logic         rvalid;
    logic         alert;
    logic         vrf;
  } ctfs_state_t;

  ctfs_state_t st_ff;
  ctfs_state_t nxt_st;

  // decode a linear word to a signed integer; fraction bits dropped
  function automatic logic signed [31:0] lin_decode(input logic [15:0] w);
    logic signed [4:0]  e;
    logic signed [31:0] m;
    e = w[EXP_MSB:EXP_LSB];
    m = 32'(signed'(w[MAN_MSB:0]));
    if (e >= 0) lin_decode = m <<< e;
    else        lin_decode = m >>> (-e);
  endfunction : lin_decode

  logic signed [31:0] iout_val;
  logic signed [31:0] temp_val;
  logic               oc_fault_hit;
  logic               oc_warn_hit;
  logic               ot_fault_hit;
  logic               ot_warn_hit;
  logic               ot_cooled;
  logic [15:0]        oc_fault_rst;

  // default fault limit: 125 percent of rated current, exponent zero
  assign oc_fault_rst = 16'((32'(RATED_MAX_CURRENT) * OC_FAULT_PCT) / 100);

  // compare measurements against decoded limits
  always_comb begin
    iout_val     = 32'(signed'(iout_meas_in));
    temp_val     = 32'(signed'(temp_meas_in));
    oc_fault_hit = iout_val > lin_decode(st_ff.lim.oc_fault);
    oc_warn_hit  = iout_val > lin_decode(st_ff.lim.oc_warn);
    ot_fault_hit = temp_val > lin_decode(st_ff.lim.ot_fault);
    ot_warn_hit  = temp_val > lin_decode(st_ff.lim.ot_warn);
    // restart point lies 15 degC under the programmed limit
    // hysteresis kept signed so limits below zero still compare correctly
    ot_cooled    = temp_val <= (lin_decode(st_ff.lim.ot_fault)
                                - signed'(32'(OT_HYST_DEG)));
  end

  // next-state logic
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.rvalid = 1'b0;
    // register writes; action registers ignore writes
    if (wr_in) begin
      case (cmd_in)
        OFS_OC_FAULT_THRESH: nxt_st.lim.oc_fault = wdata_in;
        OFS_OC_WARN_THRESH:  nxt_st.lim.oc_warn  = wdata_in;
        OFS_OT_FAULT_THRESH: nxt_st.lim.ot_fault = wdata_in;
        OFS_OT_WARN_THRESH:  nxt_st.lim.ot_warn  = wdata_in;
        default: ;
      endcase
    end
    // reads; unmapped codes answer zero
    if (rd_in) begin
      nxt_st.rvalid = 1'b1;
      case (cmd_in)
        OFS_OC_FAULT_THRESH: nxt_st.rdata = st_ff.lim.oc_fault;
        OFS_OC_FAULT_ACTION: nxt_st.rdata = {8'h00, OC_FAULT_ACTION_VAL};
        OFS_OC_WARN_THRESH:  nxt_st.rdata = st_ff.lim.oc_warn;
        OFS_OT_FAULT_THRESH: nxt_st.rdata = st_ff.lim.ot_fault;
        OFS_OT_FAULT_ACTION: nxt_st.rdata = {8'h00, OT_FAULT_ACTION_VAL};
        OFS_OT_WARN_THRESH:  nxt_st.rdata = st_ff.lim.ot_warn;
        default:             nxt_st.rdata = 16'h0000;
      endcase
    end
    // clear first so a same-cycle event still sets its bit
    if (clear_faults_in) begin
      nxt_st.st    = '0;
      nxt_st.alert = 1'b0;
      nxt_st.vrf   = 1'b0;
    end
    if (oc_fault_hit) begin
      nxt_st.st.status_byte[SB_IOUT_OC]  = 1'b1;
      nxt_st.st.status_word[SW_IOUT]     = 1'b1;
      nxt_st.st.status_iout[SI_OC_FAULT] = 1'b1;
      nxt_st.alert                       = 1'b1;
    end
    if (oc_warn_hit) begin
      nxt_st.st.status_byte[SB_OTHER]   = 1'b1;
      nxt_st.st.status_word[SW_IOUT]    = 1'b1;
      nxt_st.st.status_iout[SI_OC_WARN] = 1'b1;
      nxt_st.alert                      = 1'b1;
    end
    if (ot_fault_hit) begin
      nxt_st.st.status_byte[SB_TEMP]     = 1'b1;
      nxt_st.st.status_temp[ST_OT_FAULT] = 1'b1;
      nxt_st.alert                       = 1'b1;
      nxt_st.vrf                         = 1'b1;
    end
    if (ot_warn_hit) begin
      // warning alone never touches the fault pin
      nxt_st.st.status_byte[SB_TEMP]    = 1'b1;
      nxt_st.st.status_temp[ST_OT_WARN] = 1'b1;
      nxt_st.alert                      = 1'b1;
    end
    // low byte of the word mirrors the byte
    nxt_st.st.status_word[7:0] = nxt_st.st.status_byte;
    // shutdown and restart sequencing; temperature wins over current
    case (st_ff.mode)
      RUN: begin
        if (ot_fault_hit) begin
          nxt_st.mode = OT_COOL;
        end else if (oc_fault_hit) begin
          nxt_st.mode = OC_WAIT;
          nxt_st.cnt  = 32'(RETRY_CYCLES);
        end
      end
      OC_WAIT: begin
        if (ot_fault_hit) begin
          nxt_st.mode = OT_COOL;
        end else if (st_ff.cnt <= 32'd1) begin
          nxt_st.mode = RUN;
          nxt_st.cnt  = 32'd0;
        end else begin
          nxt_st.cnt = st_ff.cnt - 32'd1;
        end
      end
      OT_COOL: begin
        if (ot_cooled) nxt_st.mode = RUN;
      end
      default: nxt_st.mode = RUN;
    endcase
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff              <= '0;
      st_ff.mode         <= RUN;
      st_ff.lim.ot_fault <= OT_FAULT_RST;
      st_ff.lim.ot_warn  <= OT_WARN_RST;
      st_ff.lim.oc_fault <= oc_fault_rst;
      st_ff.lim.oc_warn  <= RATED_MAX_CURRENT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // output is cut the cycle the fault is seen, not one later
  assign output_enable_out   = (st_ff.mode == RUN) && !oc_fault_hit && !ot_fault_hit;
  assign rdata_out           = st_ff.rdata;
  assign rvalid_out          = st_ff.rvalid;
  assign host_alert_out      = st_ff.alert;
  assign regulator_fault_pin = st_ff.vrf;
  assign status_out          = st_ff.st;
endmodule : ctfs_supervisor

/* File: verif/ctfs_assertions.sv */
// Purpose: port assertions for the fault supervisor
// Assumes: retry span of 8 cycles or more
// Notes:   bound into every supervisor instance
`timescale 1ns/1ps
module ctfs_assertions
  import ctfs_pkg::*;
(
  input wire logic         clk_in, // clock
  input wire logic         rst_in, // reset
  input wire logic [7:0]   cmd_in, // command
  input wire logic         rd_in, // read
  input wire logic [15:0]  rdata_out, // read data
  input wire logic         host_alert_out, // alert
  input wire logic         regulator_fault_pin, // fault pin
  input wire logic         output_enable_out, // stage enable
  input wire ctfs_status_t status_out // status
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // action codes stay fixed whatever was written
  sequence s_rd(a); rd_in && cmd_in == a; endsequence
  property p_oc_act; s_rd(OFS_OC_FAULT_ACTION) |=> rdata_out == 16'h00FA; endproperty
  a_oc_act: assert property (p_oc_act) else $error("oc action code wrong");
  property p_ot_act; s_rd(OFS_OT_FAULT_ACTION) |=> rdata_out == 16'h00F8; endproperty
  a_ot_act: assert property (p_ot_act) else $error("ot action code wrong");
  // each status bit comes with its status_byte summary bit and the alert
  sequence s_oc_hit; $rose(status_out.status_iout[7]); endsequence
  property p_oc_flt;
    s_oc_hit |-> status_out.status_byte[4] && status_out.status_word[14] && host_alert_out;
  endproperty
  a_oc_flt: assert property (p_oc_flt) else $error("oc fault flags missing");
  property p_oc_off; s_oc_hit |-> !output_enable_out [*8]; endproperty
  a_oc_off: assert property (p_oc_off) else $error("restart too early");
  property p_oc_warn;
    $rose(status_out.status_iout[5]) |-> status_out.status_byte[0] && host_alert_out;
  endproperty
  a_oc_warn: assert property (p_oc_warn) else $error("oc warn flags missing");
  property p_ot_flt;
    $rose(status_out.status_temp[7]) |-> status_out.status_byte[2] && host_alert_out
      && regulator_fault_pin && !output_enable_out;
  endproperty
  a_ot_flt: assert property (p_ot_flt) else $error("overtemperature_fault_action wrong");
  property p_ot_warn;
    $rose(status_out.status_temp[6]) |-> status_out.status_byte[2] && host_alert_out;
  endproperty
  a_ot_warn: assert property (p_ot_warn) else $error("ot warn flags missing");
  // the fault pin belongs to over-temperature only
  property p_pin; regulator_fault_pin |-> status_out.status_temp[7]; endproperty
  a_pin: assert property (p_pin) else $error("fault pin without ot fault");
endmodule : ctfs_assertions
bind ctfs_supervisor ctfs_assertions i_chk (.clk_in, .rst_in, .cmd_in, .rd_in, .rdata_out,
  .host_alert_out, .regulator_fault_pin, .output_enable_out, .status_out);

/* File: verif/ctfs_host.sv */
// Purpose: host model issuing register commands
// Assumes: called right after a rising edge
// Notes:   one transfer per cycle, strobes held over one edge
`timescale 1ns/1ps
module ctfs_host (
  output logic [7:0]  cmd_out, // command
  output logic        wr_out, // write
  output logic        rd_out, // read
  output logic [15:0] wdata_out, // write data
  input  wire logic   clk_in // clock
);
  // quiet bus at time zero
  initial begin
    {cmd_out, wr_out, rd_out, wdata_out} = '0;
  end
  // one transfer, taken at the next edge
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    wr_out <= w;
    rd_out <= r;
    cmd_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
  endtask : bus
endmodule : ctfs_host

/* File: verif/tb.sv */
// Purpose: self-checking bench for the fault supervisor
// Assumes: retry span cut to RT cycles
// Notes:   read data matched against a queue of notes
`timescale 1ns/1ps
module tb;
  import ctfs_pkg::*;
  localparam int RT = 20;
  localparam logic [23:0] RV [7] = '{{OFS_OT_FAULT_THRESH, 16'h007D},
    {OFS_OT_WARN_THRESH, 16'h005F}, {OFS_OC_FAULT_THRESH, 16'h007D},
    {OFS_OC_WARN_THRESH, 16'h0064}, {OFS_OC_FAULT_ACTION, 16'h00FA},
    {OFS_OT_FAULT_ACTION, 16'h00F8}, {8'h10, 16'h0000}};
  logic         clk_in, rst_in, clr, wr, rd, rv, alert, pin, oe;
  logic [7:0]   cmd;
  logic [15:0]  wd, rdat, iout, temp, d;
  ctfs_status_t st;
  logic [15:0]  exp_q [$];
  int           err_total, checks;
  ctfs_host i_host (.clk_in(clk_in), .cmd_out(cmd), .wr_out(wr), .rd_out(rd), .wdata_out(wd));
  ctfs_supervisor #(.RETRY_CYCLES(RT)) i_dut (.clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd),
    .wr_in(wr), .rd_in(rd), .wdata_in(wd), .clear_faults_in(clr), .iout_meas_in(iout),
    .temp_meas_in(temp), .rdata_out(rdat), .rvalid_out(rv), .host_alert_out(alert),
    .regulator_fault_pin(pin), .output_enable_out(oe), .status_out(st));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic end_sim();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task automatic rd_chk(logic [7:0] a, logic [15:0] e);
    exp_q.push_back(e);
    i_host.bus(1'b0, 1'b1, a, 16'h0000);
  endtask : rd_chk
  // new measurements, idle bus carries noise rather than stale data
  task automatic go(logic [15:0] i, logic [15:0] t, int n);
    iout <= i;
    temp <= t;
    i_host.bus(1'b0, 1'b0, 8'hFF, 16'($urandom));
    repeat (n - 1) @(posedge clk_in);
  endtask : go
  task automatic clear();
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
  endtask : clear
  // sampled 1 ns after the edge so its updates have landed
  task automatic chk(logic [7:0] b, logic [7:0] io, logic [7:0] tp, logic [2:0] f);
    logic w;
    w = (io != 8'h00);
    #1;
    cmp("stat", {b, io}, {st.status_byte, st.status_iout});
    cmp("flags", {tp, w, 4'h0, f}, {st.status_temp, st.status_word[14], 4'h0, alert, pin, oe});
    cmp("word", {8'h00, b}, {8'h00, st.status_word[7:0]});
    @(posedge clk_in);
  endtask : chk
  // every read answer consumes the oldest note
  always @(posedge clk_in) begin
    if (rv === 1'b1) cmp("rdata", exp_q.size() > 0 ? exp_q.pop_front() : 'x, rdat);
  end
  initial begin
    void'($urandom(75724));
    {rst_in, clr, iout, temp} = {1'b1, 1'b0, 16'h0000, 16'h0019};
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (RV[k]) rd_chk(RV[k][23:16], RV[k][15:0]);
    i_host.bus(1'b1, 1'b0, OFS_OC_FAULT_ACTION, 16'hFFFF);
    rd_chk(OFS_OC_FAULT_ACTION, 16'h00FA);
    d = 16'($urandom);
    i_host.bus(1'b1, 1'b0, OFS_OT_FAULT_THRESH, d);
    rd_chk(OFS_OT_FAULT_THRESH, d);
    // exponent 1, mantissa 50: limit 100 degC, restart at 85
    i_host.bus(1'b1, 1'b0, OFS_OT_FAULT_THRESH, 16'h0832);
    go(16'd0, 16'd25, 2);
    clear();
    go(16'd0, 16'd96, 3);
    chk(8'h04, 8'h00, 8'h40, 3'b101);
    go(16'd0, 16'd101, 3);
    chk(8'h04, 8'h00, 8'hC0, 3'b110);
    go(16'd0, 16'd86, 5);
    chk(8'h04, 8'h00, 8'hC0, 3'b110);
    go(16'd0, 16'd85, 3);
    chk(8'h04, 8'h00, 8'hC0, 3'b111);
    clear();
    go(16'd110, 16'd25, 3);
    chk(8'h01, 8'h20, 8'h00, 3'b101);
    go(16'd50, 16'd25, 1);
    clear();
    iout <= 16'd130;
    #1 cmp("oe", 16'h0000, {15'h0000, oe});
    @(posedge clk_in);
    go(16'd50, 16'd25, 1);
    chk(8'h11, 8'hA0, 8'h00, 3'b100);
    repeat (RT - 6) @(posedge clk_in);
    chk(8'h11, 8'hA0, 8'h00, 3'b100);
    repeat (8) @(posedge clk_in);
    chk(8'h11, 8'hA0, 8'h00, 3'b101);
    end_sim();
  end
  // a hang counts as a mismatch
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule : tb
